// ===== core/ckc_device.sv
`timescale 1ns/1ns
// device end: checks received frames, appends checksum to replies
module ckc_device
  import ckc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  ckc_link_if.device link,
  input wire logic cont_read_mode,
  input wire logic tx_start,
  input wire logic [31:0] tx_word,
  input wire logic [5:0] tx_bits,
  output logic [31:0] rx_word,
  output logic [5:0] rx_bits,
  output logic rx_done,
  output logic crc_err,
  output logic tx_busy
);
  typedef enum logic [1:0] {CKC_D_IDLE, CKC_D_CMD, CKC_D_DATA, CKC_D_CRC} ckc_dstate_t;

  // receive: whole frame incl. trailing checksum shifted through divider
  logic [7:0] rcrc_reg, rcrc_next;
  logic [39:0] rsh_reg, rsh_next;
  logic [5:0] rcnt_reg, rcnt_next;
  logic [31:0] rxw_reg, rxw_next;
  logic [5:0] rxb_reg, rxb_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic [7:0] rstep;

  always_comb begin
    rcrc_next = rcrc_reg;
    rsh_next = rsh_reg;
    rcnt_next = rcnt_reg;
    rxw_next = rxw_reg;
    rxb_next = rxb_reg;
    done_next = 1'b0;
    err_next = err_reg;
    rstep = ckc_step(rcrc_reg, link.h2d_bit);
    if (link.h2d_valid) begin
      // a frame checked over data plus its own checksum leaves zero
      rcrc_next = rstep; // R4 R11
      rsh_next = {rsh_reg[38:0], link.h2d_bit};
      rcnt_next = rcnt_reg + 6'h01;
      if (link.h2d_last) begin
        rcrc_next = CKC_CRC_INIT;
        rcnt_next = 6'h00;
        done_next = 1'b1;
        // payload excludes command and checksum bytes
        rxb_next = rcnt_reg + 6'h01 - CKC_CMD_BITS - 6'(CKC_CRC_W); // R7 R8
        rxw_next = rsh_next[39:8];
        // each frame starts from an empty shifter, so short frames read back zero-filled
        rsh_next = 40'h00_0000_0000;
        if (rstep != CKC_CRC_INIT) begin
          err_next = 1'b1; // R10
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rcrc_reg <= 8'h00;
      rsh_reg <= 40'h00_0000_0000;
      rcnt_reg <= 6'h00;
      rxw_reg <= 32'h0000_0000;
      rxb_reg <= 6'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rcrc_reg <= rcrc_next;
      rsh_reg <= rsh_next;
      rcnt_reg <= rcnt_next;
      rxw_reg <= rxw_next;
      rxb_reg <= rxb_next;
      done_reg <= done_next;
      err_reg <= err_next;
    end
  end

  // transmit: implied command seeds divider in continuous read
  ckc_dstate_t ts_reg, ts_next;
  logic [7:0] tcrc_reg, tcrc_next;
  logic [31:0] tsh_reg, tsh_next;
  logic [5:0] tcnt_reg, tcnt_next;
  logic [7:0] tcmd_reg, tcmd_next;
  logic [5:0] icnt_reg, icnt_next;
  logic busy_reg, busy_next;
  logic tv_reg, tv_next;
  logic tb_reg, tb_next;
  logic tl_reg, tl_next;

  always_comb begin
    ts_next = ts_reg;
    tcrc_next = tcrc_reg;
    tsh_next = tsh_reg;
    tcnt_next = tcnt_reg;
    tv_next = 1'b0;
    tb_next = 1'b0;
    tl_next = 1'b0;
    case (ts_reg)
      CKC_D_IDLE: begin
        if (tx_start) begin
          tsh_next = tx_word << (6'd32 - tx_bits); // R6
          tcnt_next = tx_bits;
          tcrc_next = CKC_CRC_INIT; // R11
          ts_next = cont_read_mode ? CKC_D_CMD : CKC_D_DATA;
          if (cont_read_mode) begin
            tcnt_next = tx_bits;
          end
        end
      end
      CKC_D_CMD: begin
        // implied byte enters the checksum but is never sent
        tcrc_next = ckc_step(tcrc_reg, tcmd_reg[7]); // R9
        if (icnt_reg == 6'h01) begin
          ts_next = CKC_D_DATA;
        end
      end
      CKC_D_DATA: begin
        tv_next = 1'b1;
        tb_next = tsh_reg[31];
        tcrc_next = ckc_step(tcrc_reg, tsh_reg[31]); // R4 R6
        tsh_next = {tsh_reg[30:0], 1'b0};
        tcnt_next = tcnt_reg - 6'h01;
        if (tcnt_reg == 6'h01) begin
          ts_next = CKC_D_CRC;
          tcnt_next = 6'(CKC_CRC_W); // R1
        end
      end
      CKC_D_CRC: begin
        // remainder after eight zero shifts equals the divider state
        tv_next = 1'b1; // R7
        tb_next = tcrc_reg[7]; // R3 R5
        tcrc_next = {tcrc_reg[6:0], 1'b0};
        tcnt_next = tcnt_reg - 6'h01;
        if (tcnt_reg == 6'h01) begin
          tl_next = 1'b1;
          ts_next = CKC_D_IDLE;
        end
      end
      default: ts_next = CKC_D_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ts_reg <= CKC_D_IDLE;
      tcrc_reg <= 8'h00;
      tsh_reg <= 32'h0000_0000;
      tcnt_reg <= 6'h00;
      tv_reg <= 1'b0;
      tb_reg <= 1'b0;
      tl_reg <= 1'b0;
    end else begin
      ts_reg <= ts_next;
      tcrc_reg <= tcrc_next;
      tsh_reg <= tsh_next;
      tcnt_reg <= tcnt_next;
      tv_reg <= tv_next;
      tb_reg <= tb_next;
      tl_reg <= tl_next;
    end
  end

  // implied command counted out by bit, not by an emptied shifter, so any code works
  always_comb begin
    tcmd_next = tcmd_reg;
    icnt_next = icnt_reg;
    if (ts_reg == CKC_D_IDLE && tx_start) begin
      tcmd_next = CKC_CONT_READ_CMD; // R9
      icnt_next = CKC_CMD_BITS;
    end else if (ts_reg == CKC_D_CMD) begin
      tcmd_next = {tcmd_reg[6:0], 1'b0};
      icnt_next = icnt_reg - 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tcmd_reg <= 8'h00;
      icnt_reg <= 6'h00;
    end else begin
      tcmd_reg <= tcmd_next;
      icnt_reg <= icnt_next;
    end
  end

  // busy comes from its own flop so it never carries decode glitches of the state bits
  always_comb begin
    busy_next = (ts_next != CKC_D_IDLE);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  assign link.d2h_valid = tv_reg;
  assign link.d2h_bit = tb_reg;
  assign link.d2h_last = tl_reg;
  assign rx_word = rxw_reg;
  assign rx_bits = rxb_reg;
  assign rx_done = done_reg;
  // sticky until reset; no software clear exists here
  assign crc_err = err_reg;
  assign tx_busy = busy_reg;
endmodule : ckc_device

// ===== core/ckc_pkg.sv
// Operation
// R1 - checksum is exactly eight bits wide
// R2 - polynomial x^8+x^2+x+1, binary 100000111
// R3 - message extended by eight zero bits
// R4 - align polynomial to top set bit, xor
// R5 - stop below polynomial; remainder is checksum
// R6 - command then data, msb first, one message
// R7 - checksum sent right after last payload byte
// R8 - write 8-24 data bits, read 8-32 bits
// R9 - continuous read implies command byte in checksum
// R10 - device flags mismatched write checksum as error
// R11 - serial xor shift register from zero allowed
package ckc_pkg;
  localparam int CKC_CRC_W = 8;
  localparam logic [7:0] CKC_POLY = 8'h07;
  localparam logic [7:0] CKC_CRC_INIT = 8'h00;
  localparam logic [7:0] CKC_CONT_READ_CMD = 8'h42;
  localparam logic [5:0] CKC_CMD_BITS = 6'h08;
  localparam logic [5:0] CKC_WR_MIN_BITS = 6'h08;
  localparam logic [5:0] CKC_WR_MAX_BITS = 6'h18;
  localparam logic [5:0] CKC_RD_MAX_BITS = 6'h20;

  // one msb-first message bit through the divider
  function automatic logic [7:0] ckc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    ckc_step = {crc[6:0], 1'b0} ^ (fb ? CKC_POLY : 8'h00);
  endfunction : ckc_step
endpackage : ckc_pkg

// ===== core/ckc_link_if.sv
`timescale 1ns/1ns
// bit-serial link, one bit per clock, msb first, checksum follows payload
interface ckc_link_if;
  logic h2d_valid;
  logic h2d_bit;
  logic h2d_last;
  logic d2h_valid;
  logic d2h_bit;
  logic d2h_last;
  modport device (input h2d_valid, input h2d_bit, input h2d_last,
                  output d2h_valid, output d2h_bit, output d2h_last);
  modport host (output h2d_valid, output h2d_bit, output h2d_last,
                input d2h_valid, input d2h_bit, input d2h_last);
endinterface : ckc_link_if

// ===== core/ckc_host.sv
`timescale 1ns/1ns
// host end: sends command+data+checksum, checks replies
module ckc_host
  import ckc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  ckc_link_if.host link,
  input wire logic cont_read_mode,
  input wire logic wr_start,
  input wire logic [7:0] wr_cmd,
  input wire logic [23:0] wr_data,
  input wire logic [5:0] wr_bits,
  output logic wr_busy,
  output logic [31:0] rd_word,
  output logic rd_done,
  output logic rd_crc_ok
);
  typedef enum logic [1:0] {CKC_H_IDLE, CKC_H_DATA, CKC_H_CRC} ckc_hstate_t;

  ckc_hstate_t hs_reg, hs_next;
  logic [31:0] hsh_reg, hsh_next;
  logic [5:0] hcnt_reg, hcnt_next;
  logic [7:0] hcrc_reg, hcrc_next;
  logic hv_reg, hv_next;
  logic hb_reg, hb_next;
  logic hl_reg, hl_next;
  logic hbusy_reg, hbusy_next;

  always_comb begin
    hs_next = hs_reg;
    hsh_next = hsh_reg;
    hcnt_next = hcnt_reg;
    hcrc_next = hcrc_reg;
    hv_next = 1'b0;
    hb_next = 1'b0;
    hl_next = 1'b0;
    case (hs_reg)
      CKC_H_IDLE: begin
        if (wr_start) begin
          // command then data as one msb-first message
          hsh_next = {wr_cmd, wr_data << (6'd24 - wr_bits)}; // R6 R8
          hcnt_next = wr_bits + CKC_CMD_BITS;
          hcrc_next = CKC_CRC_INIT; // R11
          hs_next = CKC_H_DATA;
        end
      end
      CKC_H_DATA: begin
        hv_next = 1'b1;
        hb_next = hsh_reg[31];
        hcrc_next = ckc_step(hcrc_reg, hsh_reg[31]); // R2 R4
        hsh_next = {hsh_reg[30:0], 1'b0};
        hcnt_next = hcnt_reg - 6'h01;
        if (hcnt_reg == 6'h01) begin
          hs_next = CKC_H_CRC;
          hcnt_next = 6'(CKC_CRC_W); // R1
        end
      end
      CKC_H_CRC: begin
        hv_next = 1'b1; // R7
        hb_next = hcrc_reg[7]; // R3 R5
        hcrc_next = {hcrc_reg[6:0], 1'b0};
        hcnt_next = hcnt_reg - 6'h01;
        if (hcnt_reg == 6'h01) begin
          hl_next = 1'b1;
          hs_next = CKC_H_IDLE;
        end
      end
      default: hs_next = CKC_H_IDLE;
    endcase
    hbusy_next = (hs_next != CKC_H_IDLE);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hs_reg <= CKC_H_IDLE;
      hsh_reg <= 32'h0000_0000;
      hcnt_reg <= 6'h00;
      hcrc_reg <= 8'h00;
      hv_reg <= 1'b0;
      hb_reg <= 1'b0;
      hl_reg <= 1'b0;
      hbusy_reg <= 1'b0;
    end else begin
      hs_reg <= hs_next;
      hsh_reg <= hsh_next;
      hcnt_reg <= hcnt_next;
      hcrc_reg <= hcrc_next;
      hv_reg <= hv_next;
      hb_reg <= hb_next;
      hl_reg <= hl_next;
      hbusy_reg <= hbusy_next;
    end
  end

  // reply check; continuous read seeds with the implied command
  logic [7:0] seed;
  logic [7:0] rcrc_reg, rcrc_next;
  logic [39:0] rsh_reg, rsh_next;
  logic [31:0] rdw_reg, rdw_next;
  logic rdd_reg, rdd_next;
  logic ok_reg, ok_next;
  logic [7:0] nxt;

  always_comb begin
    seed = CKC_CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      seed = ckc_step(seed, CKC_CONT_READ_CMD[i]); // R9
    end
    rcrc_next = rcrc_reg;
    rsh_next = rsh_reg;
    rdw_next = rdw_reg;
    rdd_next = 1'b0;
    ok_next = ok_reg;
    nxt = ckc_step(rcrc_reg, link.d2h_bit);
    if (link.d2h_valid) begin
      rcrc_next = nxt; // R4
      rsh_next = {rsh_reg[38:0], link.d2h_bit};
      if (link.d2h_last) begin
        rcrc_next = cont_read_mode ? seed : CKC_CRC_INIT;
        rdw_next = rsh_next[39:8];
        rsh_next = 40'h00_0000_0000;
        rdd_next = 1'b1;
        ok_next = (nxt == CKC_CRC_INIT); // R5
      end
    end else begin
      // reseed in every gap, so a mode change between replies takes effect
      rcrc_next = cont_read_mode ? seed : CKC_CRC_INIT; // R9
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rcrc_reg <= 8'h00;
      rsh_reg <= 40'h00_0000_0000;
      rdw_reg <= 32'h0000_0000;
      rdd_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      rcrc_reg <= rcrc_next;
      rsh_reg <= rsh_next;
      rdw_reg <= rdw_next;
      rdd_reg <= rdd_next;
      ok_reg <= ok_next;
    end
  end

  assign link.h2d_valid = hv_reg;
  assign link.h2d_bit = hb_reg;
  assign link.h2d_last = hl_reg;
  assign wr_busy = hbusy_reg;
  assign rd_word = rdw_reg;
  assign rd_done = rdd_reg;
  assign rd_crc_ok = ok_reg;
endmodule : ckc_host

// ===== tb/ckc_link_checker.sv
`timescale 1ns/1ns
module ckc_link_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic h2d_valid,
  input wire logic h2d_bit,
  input wire logic h2d_last,
  input wire logic d2h_valid,
  input wire logic d2h_bit,
  input wire logic d2h_last
);
  // bits seen so far in the frame, the closing bit not yet counted
  logic [5:0] hcnt_reg, hcnt_next, dcnt_reg, dcnt_next;
  always_comb begin
    hcnt_next = h2d_last ? 6'h00 : hcnt_reg + {5'h00, h2d_valid};
    dcnt_next = d2h_last ? 6'h00 : dcnt_reg + {5'h00, d2h_valid};
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hcnt_reg <= 6'h00;
      dcnt_reg <= 6'h00;
    end else begin
      hcnt_reg <= hcnt_next;
      dcnt_reg <= dcnt_next;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_hbyte;
    (h2d_valid && !h2d_last) [*8];
  endsequence
  sequence s_dbyte;
    (d2h_valid && !d2h_last) [*8];
  endsequence
  a_host_last_valid: assert property (h2d_last |-> h2d_valid)
    else $error("host last without valid");
  a_dev_last_valid: assert property (d2h_last |-> d2h_valid)
    else $error("device last without valid");
  a_host_frame_min: assert property ($rose(h2d_valid) |-> s_hbyte ##1 s_hbyte ##1 h2d_valid [*8])
    else $error("host frame too short");
  a_dev_frame_min: assert property ($rose(d2h_valid) |-> s_dbyte ##1 d2h_valid [*8])
    else $error("device frame too short");
  a_host_bit_count: assert property (h2d_last |-> hcnt_reg[2:0] == 3'h7
    && hcnt_reg >= 6'h17 && hcnt_reg <= 6'h27)
    else $error("host frame length wrong");
  a_dev_bit_count: assert property (d2h_last |-> dcnt_reg >= 6'h0F && dcnt_reg <= 6'h27)
    else $error("device frame length wrong");
  a_host_no_gap: assert property (h2d_valid && !h2d_last |=> h2d_valid)
    else $error("gap inside host frame");
  a_dev_no_gap: assert property (d2h_valid && !d2h_last |=> d2h_valid)
    else $error("gap inside device frame");
  a_host_idle_after: assert property (h2d_last |=> !h2d_valid)
    else $error("host sends on after last");
endmodule : ckc_link_checker

// ===== tb/crc8_interface_checksum_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define WAITF(c) begin k = 0; while ((c) !== 1'b1 && k < 300) begin @(negedge clock); k++; end \
  if ((c) !== 1'b1) begin mismatches++; conclude(); end end
module crc8_interface_checksum_bench;
  import ckc_pkg::*;
  logic clock, rst_b, cm_d, cm_h, tx_start, wr_start, rx_done, crc_err, tx_busy;
  logic wr_busy, rd_done, rd_crc_ok, crc_err2;
  logic [31:0] tx_word, rx_word, rd_word;
  logic [5:0] tx_bits, wr_bits, rx_bits;
  logic [7:0] wr_cmd;
  logic [23:0] wr_data;
  logic [39:0] hsr, dsr;
  int mismatches = 0, n_tests = 0, k;
  ckc_link_if link();
  ckc_link_if link2();
  ckc_host ckc_host_i (.clock(clock), .rst_b(rst_b), .link(link), .cont_read_mode(cm_h),
    .wr_start(wr_start), .wr_cmd(wr_cmd), .wr_data(wr_data), .wr_bits(wr_bits),
    .wr_busy(wr_busy), .rd_word(rd_word), .rd_done(rd_done), .rd_crc_ok(rd_crc_ok));
  ckc_device ckc_device_i (.clock(clock), .rst_b(rst_b), .link(link), .cont_read_mode(cm_d),
    .tx_start(tx_start), .tx_word(tx_word), .tx_bits(tx_bits), .rx_word(rx_word),
    .rx_bits(rx_bits), .rx_done(rx_done), .crc_err(crc_err), .tx_busy(tx_busy));
  // second device faces a bench driver that corrupts the checksum
  ckc_device ckc_device_i2 (.clock(clock), .rst_b(rst_b), .link(link2), .cont_read_mode(1'b0),
    .tx_start(1'b0), .tx_word(32'h0), .tx_bits(6'h00), .rx_word(), .rx_bits(), .rx_done(),
    .crc_err(crc_err2), .tx_busy());
  ckc_link_checker ckc_link_checker_i (.clock(clock), .rst_b(rst_b),
    .h2d_valid(link.h2d_valid), .h2d_bit(link.h2d_bit), .h2d_last(link.h2d_last),
    .d2h_valid(link.d2h_valid), .d2h_bit(link.d2h_bit), .d2h_last(link.d2h_last));
  always @(posedge clock) begin
    if (link.h2d_valid) hsr <= {hsr[38:0], link.h2d_bit};
    if (link.d2h_valid) dsr <= {dsr[38:0], link.d2h_bit};
  end
  // plain long division, kept apart from the serial divider on purpose
  function automatic logic [7:0] ref_crc(input logic [39:0] m, input int n);
    logic [47:0] v;
    v = {m, 8'h00};
    for (int i = n + 7; i >= 8; i--) if (v[i]) v[i -: 9] = v[i -: 9] ^ 9'h107;
    return v[7:0];
  endfunction : ref_crc
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task example_frame;
    host_write(8'h65, 24'h004321, 6'h10);
    `CHK("example crc", 8'h86, hsr[7:0]);
    $display("worked example done");
  endtask : example_frame
  task host_write(input logic [7:0] c, input logic [23:0] d, input logic [5:0] b);
    logic [39:0] m;
    m = ({8'h00, c, 24'h0} >> (24 - b)) | {16'h0, d};
    @(negedge clock);
    {wr_cmd, wr_data, wr_bits, wr_start} = {c, d, b, 1'b1};
    @(negedge clock);
    wr_start = 1'b0;
    `WAITF(rx_done)
    `CHK("rx_word", m[31:0], rx_word);
    `CHK("rx_bits", b, rx_bits);
    `CHK("crc_err", 1'b0, crc_err);
    `CHK("h2d crc", ref_crc(m, b + 8), hsr[7:0]);
    `WAITF(!wr_busy)
    $display("write of %0d bits done", b);
  endtask : host_write
  task dev_reply(input logic [31:0] w, input logic [5:0] b, input logic md, input logic mh);
    logic [39:0] m;
    m = md ? ({8'h42, 32'h0} >> (32 - b)) | {8'h00, w} : {8'h00, w};
    @(negedge clock);
    {cm_d, cm_h, tx_word, tx_bits, tx_start} = {md, mh, w, b, 1'b1};
    @(negedge clock);
    tx_start = 1'b0;
    `WAITF(rd_done)
    `CHK("d2h crc", ref_crc(m, md ? b + 8 : b), dsr[7:0]);
    `CHK("rd_crc_ok", md == mh, rd_crc_ok);
    `CHK("rd_word", w, rd_word);
    `WAITF(!tx_busy)
    repeat (2) @(negedge clock);
    $display("reply of %0d bits done", b);
  endtask : dev_reply
  task bad_frame;
    logic [31:0] f;
    f = {24'h654321, 8'h87};
    for (int i = 31; i >= 0; i--) begin
      @(negedge clock);
      {link2.h2d_valid, link2.h2d_bit, link2.h2d_last} = {1'b1, f[i], i == 0};
    end
    @(negedge clock);
    {link2.h2d_valid, link2.h2d_bit, link2.h2d_last} = {1'b0, ~f[0], 1'b0};
    repeat (3) @(negedge clock);
    `CHK("crc_err2", 1'b1, crc_err2);
    `CHK("crc_err", 1'b0, crc_err);
    $display("corrupt frame done");
  endtask : bad_frame
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {rst_b, cm_d, cm_h, tx_start, wr_start, tx_word, tx_bits} = '0;
    {wr_cmd, wr_data, wr_bits} = '0;
    {link2.h2d_valid, link2.h2d_bit, link2.h2d_last} = 3'h0;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    example_frame;
    host_write(8'hA5, 24'h00005A, 6'h08);
    host_write(8'h01, 24'hFFFFFF, 6'h18);
    dev_reply(32'h89ABCDEF, 6'h20, 1'b0, 1'b0);
    dev_reply(32'h00000033, 6'h08, 1'b0, 1'b0);
    dev_reply(32'h00000000, 6'h18, 1'b1, 1'b1);
    dev_reply(32'h00123456, 6'h18, 1'b1, 1'b0);
    bad_frame;
    conclude;
  end
endmodule : crc8_interface_checksum_bench
